// ---- include/pav_params.svh ----
// constants for the acknowledge vector and init sequencer
`ifndef PAV_PARAMS_SVH
`define PAV_PARAMS_SVH
`define PAV_CALL_OPCODE 8'hcd
`define PAV_W1_IC4      0
`define PAV_W1_SOLE_CONTROLLER     1
`define PAV_W1_ADI      2
`define PAV_W1_LEVEL_TRIGGER_SELECT     3
`define PAV_W1_MARK     4
`define PAV_W4_UPM      0
`define PAV_W4_AUTO_END_OF_SERVICE     1
`define PAV_W4_MS       2
`define PAV_W4_BUF      3
`define PAV_W4_SPECIAL_NESTED_SELECT     4
`define PAV_OCW2_EOI    5
`define PAV_OCW3_MARK   3
`define PAV_OCW3_ESMM   6
`define PAV_OCW3_SMM    5
`define PAV_OCW3_RR     1
`define PAV_OCW3_RIS    0
`define PAV_BYTE_RST    8'h00
`define PAV_EDGE_RST    8'hff
`define PAV_LEVEL_NONE  3'h7
`define PAV_PULSE_FIRST 2'h0
`define PAV_PULSE_MID   2'h1
`define PAV_PULSE_LAST3 2'h2
`endif

// ---- include/pav_pkg.sv ----
// types for the acknowledge vector and init sequencer
`default_nettype none
package pav_pkg;
	typedef enum logic [4:0] {
		pav_st_wait1 = 5'b00001,
		pav_st_w2    = 5'b00010,
		pav_st_w3    = 5'b00100,
		pav_st_w4    = 5'b01000,
		pav_st_run   = 5'b10000
	} pav_init_state_type;
	typedef logic [2:0] pav_level_type;
	typedef logic [1:0] pav_pulse_type;
endpackage
`default_nettype wire

// ---- include/pav_vec_if.sv ----
// interface between the sequencer and the vector byte former
`timescale 1ns/1ps
`default_nettype none
interface pav_vec_if;
	logic       family;
	logic       spacing4;
	logic [2:0] addr_low;
	logic [7:0] high_byte;
	logic [2:0] level;
	logic [1:0] pulse;
	logic [7:0] vec_byte;
	modport former (input family, spacing4, addr_low, high_byte, level, pulse, output vec_byte);
	modport user   (output family, spacing4, addr_low, high_byte, level, pulse, input vec_byte);
endinterface
`default_nettype wire

// ---- rtl/pav_vector_former.sv ----
// forms the byte driven during each acknowledge pulse
`timescale 1ns/1ps
`default_nettype none
`include "pav_params.svh"
module pav_vector_former
	import pav_pkg::*;
(
	pav_vec_if.former vec
);
	// byte selection by cpu family, pulse index and spacing
	always_comb begin
		vec.vec_byte = `PAV_CALL_OPCODE;
		if (vec.family) begin
			vec.vec_byte = {vec.high_byte[7:3], vec.level};
		end else if (vec.pulse == `PAV_PULSE_LAST3) begin
			vec.vec_byte = vec.high_byte;
		end else if (vec.pulse == `PAV_PULSE_MID) begin
			if (vec.spacing4) begin
				vec.vec_byte = {vec.addr_low, vec.level, 2'b00};
			end else begin
				vec.vec_byte = {vec.addr_low[2:1], vec.level, 3'b000};
			end
		end
	end
endmodule // pav_vector_former
`default_nettype wire

// ---- rtl/pav_top.sv ----
// acknowledge vector generation and init word sequencing of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "pav_params.svh"
module pav_top
	import pav_pkg::*;
(
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       cs_n_in,
	input  wire logic       wr_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       a0_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe_out,
	input  wire logic       ack_strobe_n_in,
	input  wire logic [7:0] request_inputs_in,
	output logic            int_out,
	input  wire logic [2:0] cas_in,
	output logic      [2:0] cas_out,
	output logic            cas_oe_out,
	input  wire logic       role_pin_in,
	output logic            role_pin_out,
	output logic            role_pin_oe_out,
	output logic            special_nested_out
);
	pav_init_state_type state_reg;
	logic [7:0]    w1_reg, w2_reg, w3_reg, w4_reg;
	logic [7:0]    mask_reg, pending_reg, service_reg, req_prev_reg;
	logic [7:0]    pend_next, clr_sel, rise;
	logic          read_isr_reg, smm_reg, wr_prev_reg, ack_prev_reg;
	pav_pulse_type pulse_reg;
	pav_level_type level_reg;
	logic          had_reg, casc_reg;
	logic [2:0]    cas_out_reg;
	logic [7:0]    data_out_reg;
	logic          data_oe_reg, int_reg;

	// pick the highest priority set bit, flag in bit 3
	function automatic logic [3:0] pick(input logic [7:0] v);
		pick = {1'b0, `PAV_LEVEL_NONE};
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				pick = {1'b1, 3'(i)};
			end
		end
	endfunction

	// bus strobes sampled on the clock
	logic write_take, init_word_one_hit, running, ack_fall, ack_rise, read_now;
	assign write_take = wr_prev_reg & ~wr_n_in & ~cs_n_in;
	assign init_word_one_hit   = write_take & ~a0_in & data_in[`PAV_W1_MARK];
	assign running    = (state_reg == pav_st_run);
	assign ack_fall   = ack_prev_reg & ~ack_strobe_n_in;
	assign ack_rise   = ~ack_prev_reg & ack_strobe_n_in;
	assign read_now   = ~cs_n_in & ~rd_n_in;

	// configuration decode
	logic family, single, buffered, is_master, master_role, slave_hit, level_trigger_select, auto_eos;
	assign family      = w4_reg[`PAV_W4_UPM];
	assign single      = w1_reg[`PAV_W1_SOLE_CONTROLLER];
	assign buffered    = w4_reg[`PAV_W4_BUF];
	assign is_master   = buffered ? w4_reg[`PAV_W4_MS] : role_pin_in;
	assign master_role = is_master | single;
	assign slave_hit   = ~master_role & (cas_in == w3_reg[2:0]);
	assign level_trigger_select        = w1_reg[`PAV_W1_LEVEL_TRIGGER_SELECT];
	assign auto_eos    = w4_reg[`PAV_W4_AUTO_END_OF_SERVICE];
	assign special_nested_out = w4_reg[`PAV_W4_SPECIAL_NESTED_SELECT];

	// init word sequencer
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_reg <= pav_st_wait1;
		end else if (init_word_one_hit) begin
			state_reg <= pav_st_w2;
		end else if (write_take && a0_in) begin
			unique case (state_reg)
				pav_st_wait1: state_reg <= pav_st_wait1;
				pav_st_w2: begin
					if (!w1_reg[`PAV_W1_SOLE_CONTROLLER]) begin
						state_reg <= pav_st_w3;
					end else if (w1_reg[`PAV_W1_IC4]) begin
						state_reg <= pav_st_w4;
					end else begin
						state_reg <= pav_st_run;
					end
				end
				pav_st_w3: state_reg <= w1_reg[`PAV_W1_IC4] ? pav_st_w4 : pav_st_run;
				pav_st_w4: state_reg <= pav_st_run;
				pav_st_run: state_reg <= pav_st_run;
			endcase
		end
	end

	// init word storage
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			w1_reg <= `PAV_BYTE_RST;
			w2_reg <= `PAV_BYTE_RST;
			w3_reg <= `PAV_BYTE_RST;
			w4_reg <= `PAV_BYTE_RST;
		end else if (init_word_one_hit) begin
			w1_reg <= data_in;
			if (!data_in[`PAV_W1_IC4]) begin
				w4_reg <= `PAV_BYTE_RST;
			end
		end else if (write_take && a0_in) begin
			if (state_reg == pav_st_w2) w2_reg <= data_in;
			if (state_reg == pav_st_w3) w3_reg <= data_in;
			if (state_reg == pav_st_w4) w4_reg <= data_in;
		end
	end

	// command words after init: mask, read select, special mask
	logic ocw_take;
	assign ocw_take = write_take & running & ~init_word_one_hit;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || init_word_one_hit) begin
			mask_reg     <= `PAV_BYTE_RST;
			read_isr_reg <= 1'b0;
			smm_reg      <= 1'b0;
		end else if (ocw_take && a0_in) begin
			mask_reg <= data_in;
		end else if (ocw_take && data_in[`PAV_OCW3_MARK]) begin
			if (data_in[`PAV_OCW3_RR]) read_isr_reg <= data_in[`PAV_OCW3_RIS];
			if (data_in[`PAV_OCW3_ESMM]) smm_reg <= data_in[`PAV_OCW3_SMM];
		end
	end

	// priority resolution, fixed order with level 0 highest
	logic [3:0] res, srv, elig;
	logic       res_had, res_casc;
	assign res      = pick(pending_reg & ~mask_reg);
	assign srv      = pick(service_reg);
	assign elig     = pick(pending_reg & ~mask_reg & ~(smm_reg ? service_reg : 8'h00));
	assign res_had  = res[3];
	assign res_casc = master_role & ~single & res_had & w3_reg[res[2:0]];

	// level used during the current sequence
	pav_level_type cur_level;
	logic          cur_casc, cur_had, sel_pulse, last_pulse, sel_event;
	assign cur_level  = (pulse_reg == `PAV_PULSE_FIRST) ? res[2:0] : level_reg;
	assign cur_casc   = (pulse_reg == `PAV_PULSE_FIRST) ? res_casc : casc_reg;
	assign cur_had    = (pulse_reg == `PAV_PULSE_FIRST) ? res_had : had_reg;
	assign sel_pulse  = master_role ? (pulse_reg == (family ? `PAV_PULSE_MID : `PAV_PULSE_FIRST))
		: ((pulse_reg == `PAV_PULSE_MID) & slave_hit);
	assign last_pulse = (pulse_reg == (family ? `PAV_PULSE_MID : `PAV_PULSE_LAST3));
	assign sel_event  = running & ack_fall & sel_pulse & cur_had;

	// per line edge capture and pending bits
	for (genvar g = 0; g < 8; g++) begin : g_req
		assign rise[g]      = request_inputs_in[g] & ~req_prev_reg[g];
		assign clr_sel[g]   = sel_event & (cur_level == 3'(g));
		assign pend_next[g] = init_word_one_hit ? 1'b0
			: level_trigger_select ? request_inputs_in[g]
			: (rise[g] | (pending_reg[g] & ~clr_sel[g]));
	end

	// edge detector history, rearmed high on the first word
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			req_prev_reg <= `PAV_EDGE_RST;
			pending_reg  <= `PAV_BYTE_RST;
		end else begin
			req_prev_reg <= init_word_one_hit ? `PAV_EDGE_RST : request_inputs_in;
			pending_reg  <= pend_next;
		end
	end

	// in-service bits: select, automatic end, command end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || init_word_one_hit) begin
			service_reg <= `PAV_BYTE_RST;
		end else if (sel_event) begin
			service_reg[cur_level] <= 1'b1;
		end else if (running && ack_rise && last_pulse && auto_eos && had_reg) begin
			service_reg[level_reg] <= 1'b0;
		end else if (ocw_take && !a0_in && !data_in[`PAV_OCW3_MARK]
			&& data_in[`PAV_OCW2_EOI] && srv[3]) begin
			service_reg[srv[2:0]] <= 1'b0;
		end
	end

	// acknowledge pulse counter and frozen level
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || init_word_one_hit) begin
			pulse_reg <= `PAV_PULSE_FIRST;
			level_reg <= `PAV_LEVEL_NONE;
			had_reg   <= 1'b0;
			casc_reg  <= 1'b0;
		end else if (running) begin
			if (ack_fall && pulse_reg == `PAV_PULSE_FIRST) begin
				level_reg <= res[2:0];
				had_reg   <= res_had;
				casc_reg  <= res_casc;
			end
			if (ack_rise) begin
				pulse_reg <= last_pulse ? `PAV_PULSE_FIRST : pulse_reg + 2'h1;
			end
		end
	end

	// cascade code, driven by the master from the first pulse to the last
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || init_word_one_hit) begin
			cas_out_reg <= 3'h0;
		end else if (running && ack_fall && pulse_reg == `PAV_PULSE_FIRST) begin
			cas_out_reg <= res_casc ? res[2:0] : 3'h0;
		end else if (running && ack_rise && last_pulse) begin
			cas_out_reg <= 3'h0;
		end
	end
	assign cas_out    = cas_out_reg;
	assign cas_oe_out = running & master_role & ~single;

	// byte former connection
	pav_vec_if vif ();
	assign vif.family    = family;
	assign vif.spacing4  = w1_reg[`PAV_W1_ADI];
	assign vif.addr_low  = w1_reg[7:5];
	assign vif.high_byte = w2_reg;
	assign vif.level     = cur_level;
	assign vif.pulse     = pulse_reg;
	pav_vector_former u_former (
		.vec (vif)
	);

	// whether this pulse needs a byte from this device
	logic need, drive_now;
	always_comb begin
		need = master_role ? ~cur_casc : slave_hit;
		if (pulse_reg == `PAV_PULSE_FIRST) begin
			need = ~family & master_role;
		end
	end
	assign drive_now = running & ~ack_strobe_n_in & need;

	// data bus output and enable
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			data_out_reg <= `PAV_BYTE_RST;
			data_oe_reg  <= 1'b0;
		end else begin
			data_oe_reg <= drive_now | read_now;
			if (drive_now) begin
				data_out_reg <= vif.vec_byte;
			end else if (a0_in) begin
				data_out_reg <= mask_reg;
			end else begin
				data_out_reg <= read_isr_reg ? service_reg : pending_reg;
			end
		end
	end
	assign data_out    = data_out_reg;
	assign data_oe_out = data_oe_reg;

	// buffered mode turns the role pin into a low active transceiver enable
	assign role_pin_oe_out = buffered;
	assign role_pin_out    = ~data_oe_reg;

	// request line toward the cpu, fully nested compare
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wr_prev_reg  <= 1'b1;
			ack_prev_reg <= 1'b1;
			int_reg      <= 1'b0;
		end else begin
			wr_prev_reg  <= wr_n_in;
			ack_prev_reg <= ack_strobe_n_in;
			int_reg      <= running & elig[3] & (smm_reg | ~srv[3] | (elig[2:0] < srv[2:0])
				| (special_nested_out & elig[2:0] == srv[2:0]));
		end
	end
	assign int_out = int_reg;

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_call_first;
		running && ack_fall && !family && pulse_reg == `PAV_PULSE_FIRST && master_role;
	endsequence
	sequence s_mid_drive;
		drive_now && !family && pulse_reg == `PAV_PULSE_MID;
	endsequence
	a_call_opcode_out: assert property (s_call_first |=> data_oe_out && data_out == 8'hcd)
		else $error("call opcode not driven on first pulse");
	a_spacing4_byte: assert property (s_mid_drive ##0 w1_reg[2] |=> data_out == {w1_reg[7:5], level_reg, 2'b00})
		else $error("spacing 4 address byte wrong");
	a_spacing8_byte: assert property (s_mid_drive ##0 !w1_reg[2] |=> data_out == {w1_reg[7:6], level_reg, 3'b000})
		else $error("spacing 8 address byte wrong");
	a_high_addr_byte: assert property (drive_now && !family && pulse_reg == 2'h2 |=> data_out == w2_reg)
		else $error("third pulse byte is not word two");
	a_vector_first_quiet: assert property (running && family && !ack_strobe_n_in && pulse_reg == 2'h0
		&& !read_now |=> !data_oe_out)
		else $error("data bus driven on first vectored pulse");
	a_vector_byte_out: assert property (drive_now && family |=> data_out == {w2_reg[7:3], level_reg})
		else $error("vectored byte wrong");
	a_restart_clears: assert property (init_word_one_hit |=> state_reg == pav_st_w2 && mask_reg == 8'h00
		&& !read_isr_reg && !smm_reg && pending_reg == 8'h00)
		else $error("first word did not restart init");
	a_no_fourth_zero: assert property (init_word_one_hit && !data_in[0] |=> w4_reg == 8'h00)
		else $error("fourth word options not cleared");
	a_sole_skips_three: assert property (state_reg == pav_st_w2 && write_take && a0_in && !init_word_one_hit
		|=> state_reg == (!w1_reg[1] ? pav_st_w3 : w1_reg[0] ? pav_st_w4 : pav_st_run))
		else $error("init sequence order wrong");
	a_select_moves_bit: assert property (sel_event && !level_trigger_select && !rise[cur_level]
		|=> service_reg[$past(cur_level)] && !pending_reg[$past(cur_level)])
		else $error("selected level not moved to in-service");
	a_idle_level_seven: assert property (running && ack_fall && pulse_reg == 2'h0 && !res_had
		|=> level_reg == 3'h7 && cas_out == 3'h0)
		else $error("no request did not give level 7");
endmodule // pav_top
`default_nettype wire

// ---- sim/pav_host_model.sv ----
// host processor model: init writes, status reads and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module pav_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] bus_in,
	input  wire logic       data_oe_in,
	input  wire logic [2:0] cas_in,
	input  wire logic       cas_oe_in,
	output logic            cs_n_out,
	output logic            wr_n_out,
	output logic            rd_n_out,
	output logic            a0_out,
	output logic      [7:0] data_out,
	output logic            ack_n_out
);
	logic [7:0] got_byte   [3];
	logic       got_oe     [3];
	logic [2:0] got_cas    [3];
	logic       got_cas_oe [3];
	logic [7:0] rd_byte;

	// bus idle at time zero
	initial begin
		cs_n_out  = 1'b1;
		wr_n_out  = 1'b1;
		rd_n_out  = 1'b1;
		a0_out    = 1'b0;
		ack_n_out = 1'b1;
	end

	// one write strobe; released data shows the inverse, not the old value
	task automatic wr(input logic a0, input logic [7:0] d);
		@(negedge clk_in);
		cs_n_out = 1'b0;
		a0_out   = a0;
		data_out = d;
		wr_n_out = 1'b0;
		@(negedge clk_in);
		wr_n_out = 1'b1;
		cs_n_out = 1'b1;
		data_out = ~d;
	endtask

	// status read, held until the device enables its data (bounded)
	task automatic rd(input logic a0);
		int n;
		n = 0;
		@(negedge clk_in);
		cs_n_out = 1'b0;
		a0_out   = a0;
		rd_n_out = 1'b0;
		do begin
			@(negedge clk_in);
			n++;
		end while (data_oe_in !== 1'b1 && n < 4);
		rd_byte  = (data_oe_in === 1'b1) ? bus_in : 8'hxx;
		rd_n_out = 1'b1;
		cs_n_out = 1'b1;
	endtask

	// one acknowledge pulse of three cycles, recording data and cascade
	task automatic pulse(input int k);
		@(negedge clk_in);
		ack_n_out     = 1'b0;
		got_oe[k]     = 1'b0;
		got_cas_oe[k] = 1'b0;
		got_byte[k]   = 8'hxx;
		repeat (3) begin
			@(negedge clk_in);
			if (data_oe_in === 1'b1) begin
				got_oe[k]   = 1'b1;
				got_byte[k] = bus_in;
			end
			if (cas_oe_in === 1'b1) begin
				got_cas_oe[k] = 1'b1;
				got_cas[k]    = cas_in;
			end
		end
		ack_n_out = 1'b1;
		repeat (2) @(negedge clk_in);
	endtask

	// three pulses for the call form, two for the vectored form
	task automatic ack_seq(input logic vect);
		for (int k = 0; k < (vect ? 2 : 3); k++) pulse(k);
	endtask

	// two to four init bytes, each by its own write strobe
	task automatic init(input logic [7:0] w1, w2, w3, w4);
		wr(1'b0, w1);
		wr(1'b1, w2);
		if (!w1[1]) wr(1'b1, w3);
		if (w1[0]) wr(1'b1, w4);
	endtask
endmodule // pav_host_model
`default_nettype wire

// ---- sim/pav_top_tb.sv ----
// self-checking bench for the acknowledge vector and init sequencer
`timescale 1ns/1ps
`default_nettype none
module pav_top_tb;
	logic       clk_sys_in;
	logic       rst_n_in;
	logic       cs_n;
	logic       wr_n;
	logic       rd_n;
	logic       a0;
	logic [7:0] host_data;
	wire  [7:0] bus;
	logic [7:0] dout;
	logic       doe;
	logic       ack_n;
	logic [7:0] req;
	logic       int_o;
	logic [2:0] cas_drv;
	wire  [2:0] cas_w;
	logic [2:0] cas_o;
	logic       cas_oe;
	logic       role_drv;
	wire        role_w;
	logic       role_o;
	logic       role_oe;
	logic       sn;
	int         num_errors = 0;
	int         num_checks = 0;
	localparam logic [7:0] call_w1 [3] = '{8'hb6, 8'hb2, 8'h76};
	localparam logic [7:0] call_w2 [3] = '{8'h5a, 8'hc3, 8'h81};
	localparam int         call_lv [3] = '{3, 5, 7};
	localparam logic [7:0] call_b2 [3] = '{8'hac, 8'ha8, 8'h7c};

	// shared wires resolved from the device's output enables only
	assign bus    = doe ? dout : host_data;
	assign cas_w  = cas_oe ? cas_o : cas_drv;
	assign role_w = role_oe ? role_o : role_drv;

	pav_top i_dut (
		.clk_sys_in        (clk_sys_in),
		.rst_n_in          (rst_n_in),
		.cs_n_in           (cs_n),
		.wr_n_in           (wr_n),
		.rd_n_in           (rd_n),
		.a0_in             (a0),
		.data_in           (bus),
		.data_out          (dout),
		.data_oe_out       (doe),
		.ack_strobe_n_in   (ack_n),
		.request_inputs_in (req),
		.int_out           (int_o),
		.cas_in            (cas_w),
		.cas_out           (cas_o),
		.cas_oe_out        (cas_oe),
		.role_pin_in       (role_w),
		.role_pin_out      (role_o),
		.role_pin_oe_out   (role_oe),
		.special_nested_out(sn)
	);

	pav_host_model i_host (
		.clk_in    (clk_sys_in),
		.bus_in    (bus),
		.data_oe_in(doe),
		.cas_in    (cas_w),
		.cas_oe_in (cas_oe),
		.cs_n_out  (cs_n),
		.wr_n_out  (wr_n),
		.rd_n_out  (rd_n),
		.a0_out    (a0),
		.data_out  (host_data),
		.ack_n_out (ack_n)
	);

	// 20 MHz clock
	initial clk_sys_in = 1'b0;
	always #25 clk_sys_in = ~clk_sys_in;

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic done(input string name);
		$display("test %s done at %0t", name, $time);
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// rising request edge, then wait for the interrupt (bounded)
	task automatic raise(input int lvl);
		int n;
		n = 0;
		@(negedge clk_sys_in);
		req[lvl] = 1'b1;
		while (int_o !== 1'b1 && n < 10) begin
			@(negedge clk_sys_in);
			n++;
		end
		check({7'h00, int_o}, 8'h01);
	endtask

	// one interrupt served; level 8 means no request at all
	task automatic serve(input int lvl, input logic vect);
		if (lvl < 8) raise(lvl);
		i_host.ack_seq(vect);
		req = 8'h00;
	endtask

	// read the in-service bits through the read select command
	task automatic read_isr();
		i_host.wr(1'b0, 8'h0b);
		i_host.rd(1'b0);
	endtask

	// watchdog, well beyond the few hundred cycles of the tests
	initial begin
		#(50 * 20000);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end

	initial begin
		rst_n_in = 1'b0;
		req      = 8'h02;
		cas_drv  = 3'h5;
		role_drv = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		@(negedge clk_sys_in);
		check({3'h0, doe, int_o, cas_oe, role_oe, sn}, 8'h00);
		done("reset");

		// request already high: edge mode needs a fresh edge, level mode not
		i_host.init(8'h16, 8'h00, 8'h00, 8'h00);
		i_host.rd(1'b0);
		check(i_host.rd_byte, 8'h00);
		i_host.wr(1'b1, 8'h5a);
		i_host.rd(1'b1);
		check(i_host.rd_byte, 8'h5a);
		i_host.wr(1'b0, 8'h0b);
		i_host.init(8'h1e, 8'h00, 8'h00, 8'h00);
		i_host.rd(1'b1);
		check(i_host.rd_byte, 8'h00);
		i_host.rd(1'b0);
		check(i_host.rd_byte, 8'h02);
		req = 8'h00;
		done("init");

		// vectored form, spacing bit set but ignored, automatic end
		i_host.init(8'h17, 8'h48, 8'h00, 8'h03);
		serve(6, 1'b1);
		check({7'h00, i_host.got_oe[0]}, 8'h00);
		check(i_host.got_byte[1], 8'h4e);
		read_isr();
		check(i_host.rd_byte, 8'h00);
		serve(8, 1'b1);
		check(i_host.got_byte[1], 8'h4f);
		done("vectored");

		// call form without word four, both spacings
		for (int i = 0; i < 3; i++) begin
			i_host.init(call_w1[i], call_w2[i], 8'h00, 8'h00);
			serve(call_lv[i], 1'b0);
			check(i_host.got_byte[0], 8'hcd);
			check(i_host.got_byte[1], call_b2[i]);
			check(i_host.got_byte[2], call_w2[i]);
			read_isr();
			check(i_host.rd_byte, 8'h01 << call_lv[i]);
			i_host.wr(1'b0, 8'h0a);
			i_host.rd(1'b0);
			check(i_host.rd_byte, 8'h00);
			i_host.wr(1'b0, 8'h20);
		end
		done("call");

		// cascaded master: slave on line 2 gets the bytes
		i_host.init(8'h11, 8'h40, 8'h04, 8'h01);
		serve(2, 1'b1);
		check({5'h00, i_host.got_cas[0]}, 8'h02);
		check({5'h00, i_host.got_cas_oe[0], i_host.got_oe[0], i_host.got_oe[1]}, 8'h04);
		i_host.wr(1'b0, 8'h20);
		// slave with identity 5: answers only on a matching code
		role_drv = 1'b0;
		i_host.init(8'h11, 8'h40, 8'h05, 8'h01);
		serve(4, 1'b1);
		check(i_host.got_byte[1], 8'h44);
		cas_drv = 3'h3;
		serve(3, 1'b1);
		check({6'h00, i_host.got_cas_oe[1], i_host.got_oe[1]}, 8'h00);
		// buffered master with special nesting
		role_drv = 1'b1;
		i_host.init(8'h13, 8'h40, 8'h00, 8'h1d);
		@(negedge clk_sys_in);
		check({5'h00, role_oe, sn, role_o}, 8'h07);
		check({7'h00, doe}, 8'h00);
		done("cascade");
		summarize();
	end
endmodule // pav_top_tb
`default_nettype wire
